/* core/hbw_defines.svh */
/*
  Constants of the heartbeat writer: register offsets, bit positions,
  submessage codes and field layout.
  Assumes inclusion by bare name from every core file that needs them.
*/
`ifndef HBW_DEFINES_SVH
`define HBW_DEFINES_SVH

// register byte offsets
`define HBW_OFF_CTRL      8'h00
`define HBW_OFF_STATUS    8'h04
`define HBW_OFF_READER    8'h08
`define HBW_OFF_WRITER    8'h0c
`define HBW_OFF_SAMPLE    8'h10
`define HBW_OFF_HIGHEST   8'h14
`define HBW_OFF_LOWEST    8'h18
`define HBW_OFF_COUNT     8'h1c
`define HBW_OFF_GCUR      8'h20
`define HBW_OFF_GFIRST    8'h24
`define HBW_OFF_GLAST     8'h28
`define HBW_OFF_DIGEST    8'h2c
`define HBW_OFF_SECDIGEST 8'h30

// control register bits
`define HBW_CTRL_SEND  0
`define HBW_CTRL_FINAL 1
`define HBW_CTRL_ALIVE 2
`define HBW_CTRL_GROUP 3
`define HBW_CTRL_ORDER 4

// status register bits
`define HBW_ST_BUSY     0
`define HBW_ST_REFUSED  1
`define HBW_ST_PEER_ERR 2

// sample event register bits
`define HBW_EVT_WROTE  0
`define HBW_EVT_RETIRE 1

// submessage header flag bits
`define HBW_FLAG_ORDER 0
`define HBW_FLAG_FINAL 1
`define HBW_FLAG_ALIVE 2
`define HBW_FLAG_GROUP 3

`define HBW_SUBMSG_ID  8'h07
`define HBW_LEN_BASE   16'h001c
`define HBW_LEN_GROUP  16'h003c
`define HBW_FI_BASE    5'h09
`define HBW_FI_GROUP   5'h11
`define HBW_SEQ_RESET_LOW  32'h00000001
`define HBW_SEQ_RESET_HIGH 32'h00000000

`endif

/* core/hbw_pkg.sv */
/*
  Types of the heartbeat writer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package hbw_pkg;
  typedef enum logic {hbw_idle, hbw_send} hbw_state_e;
endpackage

`default_nettype wire

/* core/hbw_sync2.sv */
/*
  Two-flop synchroniser for levels arriving from outside the clock domain.
  Assumes the input is a slow level that may be sampled late by a cycle.
*/
`default_nettype none

module hbw_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // meta feeds nothing but q
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

/* core/hbw_byte_pick.sv */
/*
  Picks one byte of a field of one to four bytes in the requested order.
  Assumes idx stays below nbytes.
*/
`default_nettype none

module hbw_byte_pick (
  input  wire logic [31:0] value,
  input  wire logic [2:0]  nbytes,
  input  wire logic [1:0]  idx,
  input  wire logic        little,
  output logic      [7:0]  byte_out
);

  wire [2:0] be_idx = nbytes - 3'h1 - {1'b0, idx};
  wire [1:0] sel    = little ? idx : be_idx[1:0];

  assign byte_out = value[{sel, 3'h0} +: 8];

endmodule

`default_nettype wire

/* core/hbw_heartbeat_writer.sv */
/*
  Writer end of the heartbeat submessage: keeps the writer's sequence
  state, builds the submessage and streams it out a byte per cycle.
  Assumes a plain register port driven on mclk and a reader that takes
  a byte on every cycle that hb_valid is high; peer_error is a pin.
*/
// Decided for this implementation: the plain strobed port and the register addresses.
// Contract
// - a header flag gives the byte order of multi-byte fields.
// - final flag says whether the reader must answer.
// - liveliness flag means the writer asserted it is alive.
// - group flag adds five trailing group fields, absent otherwise.
// - with samples held, first field is lowest held sequence.
// - with nothing held, first field is next unwritten sequence.
// - last field is highest sequence ever written.
// - count rises for every new heartbeat; reader drops duplicates.
// - current group field is the group's highest written number.
// - first and last group fields match first and last samples.
// - digest names the group members; secure digest is reserved.
`default_nettype none
`include "hbw_defines.svh"

module hbw_heartbeat_writer (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        peer_error,
  output logic      [7:0]  hb_byte,
  output logic             hb_valid,
  output logic             hb_last
);

  ////////////////////////////////////////////////////////////////////////
  // state

  hbw_pkg::hbw_state_e state;
  logic        flag_final;
  logic        flag_alive;
  logic        flag_group;
  logic        flag_little;
  logic [31:0] reader_ent;
  logic [31:0] writer_ent;
  logic [31:0] g_cur;
  logic [31:0] g_first;
  logic [31:0] g_last;
  logic [31:0] digest;
  logic [31:0] sec_digest;
  logic [31:0] highest;
  logic [31:0] lowest;
  logic [31:0] hb_count;
  logic        refused;
  logic        peer_err_flag;
  logic [3:0]  snap_flags;
  logic [31:0] snap_first;
  logic [31:0] snap_last;
  logic [4:0]  fi;
  logic [1:0]  bi;
  logic        err_sync;
  logic [31:0] field_val;
  logic [2:0]  field_len;
  logic        field_raw;
  logic [7:0]  pick_byte;

  ////////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_ctrl   = reg_wr && (reg_addr == `HBW_OFF_CTRL);
  wire wr_status = reg_wr && (reg_addr == `HBW_OFF_STATUS);
  wire wr_sample = reg_wr && (reg_addr == `HBW_OFF_SAMPLE);
  wire send_req  = wr_ctrl && reg_wdata[`HBW_CTRL_SEND];
  wire busy      = (state == hbw_pkg::hbw_send);

  // refuse group values that a reader would reject, not send them
  wire [32:0] g_last_p1 = {1'b0, g_last} + 33'h000000001;
  wire group_bad = (g_cur == 32'h0) || (g_first == 32'h0)
                 || (g_last_p1 < {1'b0, g_first})
                 || (g_cur < g_first) || (g_cur < g_last);
  wire start  = send_req && !busy && !(reg_wdata[`HBW_CTRL_GROUP] && group_bad);
  wire refuse = send_req && !start;

  wire wrote  = wr_sample && reg_wdata[`HBW_EVT_WROTE];
  // nothing retires past the newest sample, so lowest stays at most highest+1
  wire retire = wr_sample && reg_wdata[`HBW_EVT_RETIRE] && (lowest <= highest);

  wire [31:0] ctrl_rd   = {27'h0, flag_little, flag_group, flag_alive, flag_final, 1'b0};
  wire [31:0] status_rd = {29'h0, peer_err_flag, refused, busy};
  wire [31:0] rd_mux =
      (reg_addr == `HBW_OFF_CTRL)      ? ctrl_rd    :
      (reg_addr == `HBW_OFF_STATUS)    ? status_rd  :
      (reg_addr == `HBW_OFF_READER)    ? reader_ent :
      (reg_addr == `HBW_OFF_WRITER)    ? writer_ent :
      (reg_addr == `HBW_OFF_HIGHEST)   ? highest    :
      (reg_addr == `HBW_OFF_LOWEST)    ? lowest     :
      (reg_addr == `HBW_OFF_COUNT)     ? hb_count   :
      (reg_addr == `HBW_OFF_GCUR)      ? g_cur      :
      (reg_addr == `HBW_OFF_GFIRST)    ? g_first    :
      (reg_addr == `HBW_OFF_GLAST)     ? g_last     :
      (reg_addr == `HBW_OFF_DIGEST)    ? digest     :
      (reg_addr == `HBW_OFF_SECDIGEST) ? sec_digest : 32'h0;

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flag_final  <= 1'b0;
      flag_alive  <= 1'b0;
      flag_group  <= 1'b0;
      flag_little <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      flag_final  <= reg_wdata[`HBW_CTRL_FINAL];
      flag_alive  <= reg_wdata[`HBW_CTRL_ALIVE];
      flag_group  <= reg_wdata[`HBW_CTRL_GROUP];
      flag_little <= reg_wdata[`HBW_CTRL_ORDER];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reader_ent <= 32'h0;
      writer_ent <= 32'h0;
      g_cur      <= 32'h0;
      g_first    <= 32'h0;
      g_last     <= 32'h0;
      digest     <= 32'h0;
      sec_digest <= 32'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `HBW_OFF_READER)    reader_ent <= reg_wdata;
      if (reg_addr == `HBW_OFF_WRITER)    writer_ent <= reg_wdata;
      if (reg_addr == `HBW_OFF_GCUR)      g_cur      <= reg_wdata;
      if (reg_addr == `HBW_OFF_GFIRST)    g_first    <= reg_wdata;
      if (reg_addr == `HBW_OFF_GLAST)     g_last     <= reg_wdata;
      if (reg_addr == `HBW_OFF_DIGEST)    digest     <= reg_wdata;
      if (reg_addr == `HBW_OFF_SECDIGEST) sec_digest <= reg_wdata;
    end
  end

  // sequence bookkeeping; empty history reads as lowest = highest + 1
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      highest <= `HBW_SEQ_RESET_HIGH;
      lowest  <= `HBW_SEQ_RESET_LOW;
    end
    else
    begin
      if (wrote)
        highest <= highest + 32'h1;
      if (retire)
        lowest <= lowest + 32'h1;
    end
  end

  // sticky status; a set in the clearing cycle wins
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      refused       <= 1'b0;
      peer_err_flag <= 1'b0;
    end
    else
    begin
      refused       <= refuse ||
                       (refused && !(wr_status && reg_wdata[`HBW_ST_REFUSED]));
      peer_err_flag <= err_sync ||
                       (peer_err_flag && !(wr_status && reg_wdata[`HBW_ST_PEER_ERR]));
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  hbw_sync2 #(.W(1)) u_err_sync (
    .clk (mclk),
    .rst (sys_rst),
    .d   (peer_error),
    .q   (err_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // framing

  // sequence values are frozen at start so a retire mid-frame stays coherent
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      snap_flags <= 4'h0;
      snap_first <= 32'h0;
      snap_last  <= 32'h0;
      hb_count   <= 32'h0;
    end
    else if (start)
    begin
      snap_flags[`HBW_FLAG_ORDER] <= reg_wdata[`HBW_CTRL_ORDER];
      snap_flags[`HBW_FLAG_FINAL] <= reg_wdata[`HBW_CTRL_FINAL];
      snap_flags[`HBW_FLAG_ALIVE] <= reg_wdata[`HBW_CTRL_ALIVE];
      snap_flags[`HBW_FLAG_GROUP] <= reg_wdata[`HBW_CTRL_GROUP];
      snap_first <= lowest;
      snap_last  <= highest;
      hb_count   <= hb_count + 32'h1;
    end
  end

  wire       snap_group = snap_flags[`HBW_FLAG_GROUP];
  wire [4:0] last_fi    = snap_group ? `HBW_FI_GROUP : `HBW_FI_BASE;
  wire [15:0] sub_len   = snap_group ? `HBW_LEN_GROUP : `HBW_LEN_BASE;
  wire field_end = ({1'b0, bi} == (field_len - 3'h1));
  wire frame_end = field_end && (fi == last_fi);

  // field table; sequence numbers go out as high word then low word
  always_comb
  begin
    field_val = 32'h0;
    field_len = 3'h4;
    field_raw = 1'b0;
    case (fi)
      5'h00:   begin field_val = {24'h0, `HBW_SUBMSG_ID}; field_len = 3'h1; end
      5'h01:   begin field_val = {28'h0, snap_flags}; field_len = 3'h1; end
      5'h02:   begin field_val = {16'h0, sub_len}; field_len = 3'h2; end
      5'h03:   begin field_val = reader_ent; field_raw = 1'b1; end
      5'h04:   begin field_val = writer_ent; field_raw = 1'b1; end
      5'h06:   field_val = snap_first;
      5'h08:   field_val = snap_last;
      5'h09:   field_val = hb_count;
      5'h0b:   field_val = g_cur;
      5'h0d:   field_val = g_first;
      5'h0f:   field_val = g_last;
      5'h10:   begin field_val = digest; field_raw = 1'b1; end
      5'h11:   begin field_val = sec_digest; field_raw = 1'b1; end
      default: field_val = 32'h0;
    endcase
  end

  // entity codes and digests are byte arrays and ignore the byte order
  hbw_byte_pick u_pick (
    .value    (field_val),
    .nbytes   (field_len),
    .idx      (bi),
    .little   (snap_flags[`HBW_FLAG_ORDER] && !field_raw),
    .byte_out (pick_byte)
  );

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= hbw_pkg::hbw_idle;
      fi    <= 5'h0;
      bi    <= 2'h0;
    end
    else
    begin
      case (state)
        hbw_pkg::hbw_idle:
        begin
          fi <= 5'h0;
          bi <= 2'h0;
          if (start)
            state <= hbw_pkg::hbw_send;
        end
        hbw_pkg::hbw_send:
        begin
          if (frame_end)
            state <= hbw_pkg::hbw_idle;
          else if (field_end)
          begin
            fi <= fi + 5'h1;
            bi <= 2'h0;
          end
          else
            bi <= bi + 2'h1;
        end
        default: state <= hbw_pkg::hbw_idle;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hb_byte  <= 8'h0;
      hb_valid <= 1'b0;
      hb_last  <= 1'b0;
    end
    else
    begin
      hb_byte  <= busy ? pick_byte : 8'h0;
      hb_valid <= busy;
      hb_last  <= busy && frame_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence id_byte_s;
    hb_valid && (hb_byte == `HBW_SUBMSG_ID);
  endsequence

  sequence flags_byte_s;
    hb_valid && (hb_byte[7:4] == 4'h0);
  endsequence

  header_order_a: assert property (
    start |-> ##2 id_byte_s ##1
      (flags_byte_s and (hb_byte[`HBW_FLAG_ORDER] == $past(reg_wdata[`HBW_CTRL_ORDER], 3))))
    else $error("byte order flag differs from request");

  header_final_a: assert property (
    start |-> ##3 (hb_byte[`HBW_FLAG_FINAL] == $past(reg_wdata[`HBW_CTRL_FINAL], 3)))
    else $error("final flag differs from request");

  header_alive_a: assert property (
    start |-> ##3 (hb_byte[`HBW_FLAG_ALIVE] == $past(reg_wdata[`HBW_CTRL_ALIVE], 3)))
    else $error("liveliness flag differs from request");

  base_length_a: assert property (
    (start && !reg_wdata[`HBW_CTRL_GROUP]) |-> ##33 (hb_valid && hb_last))
    else $error("plain heartbeat not 32 bytes");

  group_length_a: assert property (
    (start && reg_wdata[`HBW_CTRL_GROUP]) |-> ##65 (hb_valid && hb_last))
    else $error("group heartbeat not 64 bytes");

  count_step_a: assert property (
    start |=> (hb_count == $past(hb_count) + 32'h1) && busy)
    else $error("count did not step once per heartbeat");

  first_seq_a: assert property (
    (lowest != 32'h0) && ({1'b0, lowest} <= {1'b0, highest} + 33'h000000001))
    else $error("lowest available sequence out of range");

  last_seq_a: assert property (
    wrote |=> (highest == $past(highest) + 32'h1))
    else $error("highest written sequence did not advance");

  group_refuse_a: assert property (
    (send_req && !busy && reg_wdata[`HBW_CTRL_GROUP] && group_bad)
      |=> refused && !busy)
    else $error("bad group values were not refused");

  peer_error_a: assert property (
    $rose(peer_error) ##1 peer_error |-> ##2 peer_err_flag)
    else $error("peer error not recorded");

endmodule

`default_nettype wire

/* tb/hbw_reader_model.sv */
/*
  Reader model: collects heartbeat bytes, judges each frame and raises
  peer_error for four cycles on a frame it rejects.
  Assumes one byte per mclk while hb_valid is high, frames apart.
*/
`default_nettype none

module hbw_reader_model (
  input  wire logic       mclk,
  input  wire logic [7:0] hb_byte,
  input  wire logic       hb_valid,
  input  wire logic       hb_last,
  input  wire logic       force_bad,
  output logic            peer_error
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0]  cap[$];
  int          nframes  = 0;
  int          err_left = 0;
  int          acks     = 0;
  int          leases   = 0;
  logic        was_valid = 1'b0;
  logic [31:0] last_cnt = 32'h0;

  initial peer_error = 1'b0;

  function automatic logic [31:0] get32(input int i, input bit le);
    return le ? {cap[i+3], cap[i+2], cap[i+1], cap[i]}
              : {cap[i], cap[i+1], cap[i+2], cap[i+3]};
  endfunction

  // high words are ignored: the writer keeps values below 2**32
  // group words are read only once the frame is known to hold them
  function automatic bit bad_frame();
    bit          le;
    logic [32:0] f, l, c, gf, gl;
    le = cap[1][0];
    if (cap.size() < 4 + (le ? {cap[3], cap[2]} : {cap[2], cap[3]}))
      return 1'b1;
    f  = {1'b0, get32(16, le)};
    l  = {1'b0, get32(24, le)};
    if (f == 0 || l + 1 < f)
      return 1'b1;
    if (!cap[1][3] || cap.size() < 56)
      return cap[1][3];
    c  = {1'b0, get32(36, le)};
    gf = {1'b0, get32(44, le)};
    gl = {1'b0, get32(52, le)};
    return c == 0 || gf == 0 || gl + 1 < gf || c < gf || c < gl;
  endfunction

  // any reader field is accepted, so a wildcard entity reaches us
  // prefixes are constants, so no frame can alter them
  localparam logic [31:0] src_prefix = 32'h5a5a0001;
  localparam logic [31:0] dst_prefix = 32'h5a5a0002;
  logic [63:0] writer_guid = 64'h0;
  logic [63:0] reader_guid = 64'h0;
  always @(posedge mclk)
  begin
    if (hb_valid && !was_valid)
      cap.delete();
    if (hb_valid)
      cap.push_back(hb_byte);
    if (hb_valid && hb_last)
    begin
      nframes++;
      if (force_bad || bad_frame())
        err_left = 4;
      else
      begin
        writer_guid = {src_prefix, get32(8, 1'b0)};
        reader_guid = {dst_prefix, get32(4, 1'b0)};
        if (get32(28, cap[1][0]) > last_cnt)
        begin
          last_cnt = get32(28, cap[1][0]);
          if (!cap[1][1])
            acks++;
          if (cap[1][2])
            leases++;
        end
      end
    end
    was_valid <= hb_valid;
    peer_error <= err_left > 0;
    if (err_left > 0)
      err_left--;
  end
endmodule

`default_nettype wire

/* tb/hbw_heartbeat_writer_tb.sv */
/*
  Testbench of the heartbeat writer: register tasks, frame builder and
  the scenario sequence.
  Assumes the reader model and the core files are compiled before it.
*/
`default_nettype none
`include "hbw_defines.svh"

module hbw_heartbeat_writer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // entity and digest values are arbitrary
  localparam logic [31:0] rid = 32'h01020304;
  localparam logic [31:0] wid = 32'ha5b6c7d2;
  localparam logic [31:0] dg  = 32'h0f1e2d3c;
  localparam logic [31:0] sd  = 32'h11223344;
  localparam logic [31:0] bc[5] = '{32'h0, 32'h5, 32'h5, 32'h3, 32'h2};
  localparam logic [31:0] bf[5] = '{32'h2, 32'h0, 32'h5, 32'h4, 32'h2};
  localparam logic [31:0] bl[5] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h3};

  logic        mclk, sys_rst, reg_wr, reg_rd, peer_error;
  logic        hb_valid, hb_last, force_bad;
  logic [7:0]  reg_addr, hb_byte;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0]  exp_q[$];
  int          n_fail = 0;
  int          n_compared = 0;

  hbw_heartbeat_writer hbw_heartbeat_writer_inst (.mclk(mclk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .peer_error(peer_error), .hb_byte(hb_byte),
    .hb_valid(hb_valid), .hb_last(hb_last));
  hbw_reader_model hbw_reader_model_inst (.mclk(mclk), .hb_byte(hb_byte),
    .hb_valid(hb_valid), .hb_last(hb_last), .force_bad(force_bad),
    .peer_error(peer_error));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] want, input string what);
    n_compared++;
    if (got !== want)
    begin
      n_fail++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
    cmp32({24'h0, got}, {24'h0, want}, "frame byte");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic chk(input logic [7:0] a, input logic [31:0] want);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    cmp32(reg_rdata, want, "register");
  endtask

  task automatic wait_frame(input int n);
    for (int k = 0; k < 200 && hbw_reader_model_inst.nframes == n; k++)
      @(posedge mclk);
    if (hbw_reader_model_inst.nframes == n)
    begin
      n_fail++;
      $display("ERROR at %0t: no frame arrived", $time);
    end
  endtask

  function automatic void p32(input logic [31:0] v, input bit le);
    for (int i = 0; i < 4; i++)
      exp_q.push_back(le ? v[8*i +: 8] : v[8*(3-i) +: 8]);
  endfunction

  function automatic void seq(input logic [31:0] v, input bit le);
    p32(32'h0, le);
    p32(v, le);
  endfunction

  task automatic send_chk(input bit fin, alv, grp, le, input logic [31:0] lo, hi, cnt);
    int         n;
    logic [7:0] ln;
    n = hbw_reader_model_inst.nframes;
    ln = grp ? 8'h3c : 8'h1c;
    exp_q.delete();
    exp_q.push_back(`HBW_SUBMSG_ID);
    exp_q.push_back({4'h0, grp, alv, fin, le});
    exp_q.push_back(le ? ln : 8'h00);
    exp_q.push_back(le ? 8'h00 : ln);
    p32(rid, 1'b0);
    p32(wid, 1'b0);
    seq(lo, le);
    seq(hi, le);
    p32(cnt, le);
    if (grp)
    begin
      seq(32'h5, le);
      seq(32'h4, le);
      seq(32'h3, le);
      p32(dg, 1'b0);
      p32(sd, 1'b0);
    end
    wr(`HBW_OFF_CTRL, {27'h0, le, grp, alv, fin, 1'b1});
    wait_frame(n);
    cmp32(32'(hbw_reader_model_inst.cap.size()), 32'(exp_q.size()), "frame size");
    foreach (exp_q[i])
      cmp8(hbw_reader_model_inst.cap[i], exp_q[i]);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2_000_000;
    n_fail++;
    print_verdict();
  end

  initial
  begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    force_bad = 1'b0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    chk(`HBW_OFF_HIGHEST, 32'h0);
    chk(`HBW_OFF_LOWEST, 32'h1);
    chk(`HBW_OFF_COUNT, 32'h0);
    chk(8'h40, 32'h0);
    wr(`HBW_OFF_READER, rid);
    wr(`HBW_OFF_WRITER, wid);
    wr(`HBW_OFF_DIGEST, dg);
    wr(`HBW_OFF_SECDIGEST, sd);
    chk(`HBW_OFF_WRITER, wid);
    send_chk(0, 0, 0, 0, 32'h1, 32'h0, 32'h1);
    repeat (3) wr(`HBW_OFF_SAMPLE, 32'h1);
    wr(`HBW_OFF_SAMPLE, 32'h2);
    send_chk(1, 1, 0, 1, 32'h2, 32'h3, 32'h2);
    chk(`HBW_OFF_CTRL, 32'h16);
    wr(`HBW_OFF_GCUR, 32'h5);
    wr(`HBW_OFF_GFIRST, 32'h4);
    wr(`HBW_OFF_GLAST, 32'h3);
    send_chk(0, 0, 1, 0, 32'h2, 32'h3, 32'h3);
    for (int i = 0; i < 5; i++)
    begin
      wr(`HBW_OFF_GCUR, bc[i]);
      wr(`HBW_OFF_GFIRST, bf[i]);
      wr(`HBW_OFF_GLAST, bl[i]);
      wr(`HBW_OFF_CTRL, 32'h9);
      chk(`HBW_OFF_STATUS, 32'h2);
      wr(`HBW_OFF_STATUS, 32'h2);
    end
    chk(`HBW_OFF_COUNT, 32'h3);
    // second send lands while busy and must not make a second frame
    wr(`HBW_OFF_CTRL, 32'h1);
    wr(`HBW_OFF_CTRL, 32'h1);
    chk(`HBW_OFF_STATUS, 32'h3);
    wait_frame(3);
    repeat (40) @(posedge mclk);
    chk(`HBW_OFF_COUNT, 32'h4);
    chk(`HBW_OFF_STATUS, 32'h2);
    wr(`HBW_OFF_STATUS, 32'h2);
    repeat (3) wr(`HBW_OFF_SAMPLE, 32'h2);
    chk(`HBW_OFF_LOWEST, 32'h4);
    send_chk(0, 0, 0, 1, 32'h4, 32'h3, 32'h5);
    force_bad <= 1'b1;
    send_chk(1, 0, 0, 0, 32'h4, 32'h3, 32'h6);
    force_bad <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(`HBW_OFF_STATUS, 32'h4);
    wr(`HBW_OFF_STATUS, 32'h4);
    chk(`HBW_OFF_STATUS, 32'h0);
    cmp32(32'(hbw_reader_model_inst.nframes), 32'h6, "frames");
    cmp32(32'(hbw_reader_model_inst.acks), 32'h4, "acknowledgements");
    cmp32(32'(hbw_reader_model_inst.leases), 32'h1, "lease renewals");
    cmp32(hbw_reader_model_inst.writer_guid[31:0], wid, "writer identity");
    cmp32(hbw_reader_model_inst.reader_guid[31:0], rid, "reader identity");
    print_verdict();
  end
endmodule

`default_nettype wire
